// >>> src/fdpm_top.sv
// Floppy drive pin interface with parallel port and density pin sharing
`timescale 1ns/100ps
`include "fdpm_params.svh"
module fdpm_top import fdpm_pkg::*; #(
	parameter int STEP_PULSE_CYC = `FDPM_STEP_PULSE_CYC
) (
	input wire logic mclk, // System clock, 200 MHz
	input wire logic sys_rst, // Async reset, active high
	// Configuration
	input wire logic [1:0] ext_mode_sel, // Parallel pin mode
	input wire logic [1:0] den_pin_func, // Density pin 1 function
	input wire logic drive_input_pullup_disable, // Kill drive pull-ups
	// Controller core side
	input wire logic core_head_side1, // 1 selects side 1
	input wire logic core_write_gate, // Write enable request
	input wire logic core_write_pulse, // Precompensated write bit
	input wire logic core_step_strobe, // One-cycle step request
	input wire logic core_dir_inward, // 1 steps inward
	input wire logic core_motor_a_on, // Drive 0 motor on
	input wire logic core_motor_b_on, // Drive 1 motor on
	input wire logic core_drive_sel_a, // Select drive A
	input wire logic core_drive_sel_b, // Select drive B
	input wire logic core_density0, // Density select bit 0
	input wire logic core_density1, // Density select bit 1
	input wire logic core_ext_motor_a_on, // Extension A motor on
	input wire logic core_ext_drive_sel_a, // Extension A select
	input wire logic core_ext_access, // Read from extension drive
	output logic drv_disk_change_n, // Selected disk change
	output logic drv_read_serial_n, // Selected read data
	output logic drv_write_protect_n, // Selected write protect
	output logic drv_track_zero_n, // Selected track zero
	output logic drv_index_n, // Selected index
	// Printer logic side
	input wire logic [7:0] prn_data_o, // Printer data out
	input wire logic prn_data_oe, // Printer drives data
	output logic [7:0] prn_data_in, // Synchronised data pins
	// Alternate density pin users
	input wire logic gpio_port1_bit0_o, // GPIO level
	input wire logic gpio_port1_bit0_oe, // GPIO enable
	output logic gpio_port1_bit0, // GPIO input level
	output logic irq_channel_in1, // Interrupt input from GPIO
	input wire logic kbc_port_o, // Keyboard port level
	input wire logic kbc_port_oe, // Keyboard port enable
	output logic kbc_port_pin, // Keyboard port input
	input wire logic system_control_irq_n, // SCI level to drive
	// Drive cable pins
	output logic head_sel_n_o, // Head select level
	output logic head_sel_n_oe, // Head select drive
	output logic write_gate_n_o, // Write enable level
	output logic write_gate_n_oe, // Write enable drive
	output logic write_serial_n_o, // Write data level
	output logic write_serial_n_oe, // Write data drive
	output logic step_n_o, // Step level
	output logic step_n_oe, // Step drive
	output logic dir_n_o, // Direction level
	output logic dir_n_oe, // Direction drive
	output logic motor_a_on_n_o, // Motor A level
	output logic motor_a_on_n_oe, // Motor A drive
	output logic motor_b_on_n_o, // Motor B level
	output logic motor_b_on_n_oe, // Motor B drive
	output logic drive_sel_a_n_o, // Select A level
	output logic drive_sel_a_n_oe, // Select A drive
	output logic drive_sel_b_n_o, // Select B level
	output logic drive_sel_b_n_oe, // Select B drive
	output logic density_sel_bit0_o, // Density 0 level
	output logic density_sel_bit0_oe, // Density 0 drive
	input wire logic density_sel_bit1_i, // Density 1 pin level
	output logic density_sel_bit1_o, // Density 1 level
	output logic density_sel_bit1_oe, // Density 1 drive
	input wire logic disk_change_n, // Disk change pin
	input wire logic read_serial_n, // Read data pin
	input wire logic write_protect_n, // Write protect pin
	input wire logic track_zero_n, // Track zero pin
	input wire logic index_n, // Index pin
	output logic drive_pullup_en, // Drive input pull-ups on
	input wire logic [7:0] par_data_pin_i, // Parallel data pins
	output logic [7:0] par_data_pin_o, // Parallel data levels
	output logic [7:0] par_data_pin_oe, // Parallel data drive
	output logic [7:0] par_pullup_en // Parallel pin pull-ups on
);

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	fdpm_mode_t mode;
	logic ext_mode;

	always_comb begin
		case (ext_mode_sel)
			`FDPM_MODE_EXT_SINGLE: mode = FDPM_EXT_SINGLE;
			`FDPM_MODE_EXT_DUAL: mode = FDPM_EXT_DUAL;
			default: mode = FDPM_PRINTER;
		endcase
	end

	assign ext_mode = (mode != FDPM_PRINTER);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Pull-ups idle these lines high, so reset to released
	logic [4:0] main_sync;
	logic [7:0] par_sync;
	logic den1_sync;

	fdpm_sync #(
		.WIDTH(5),
		.RST_VAL(5'h1F)
	) u_main_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.async_in({disk_change_n, read_serial_n, write_protect_n,
			track_zero_n, index_n}),
		.sync_out(main_sync)
	);

	fdpm_sync #(
		.WIDTH(9),
		.RST_VAL(9'h1FF)
	) u_par_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.async_in({density_sel_bit1_i, par_data_pin_i}),
		.sync_out({den1_sync, par_sync})
	);

	logic main_disk_change_n_n;
	logic main_rdata_n;
	logic main_wp_n;
	logic main_trk0_n;
	logic main_index_n;
	logic ext_disk_change_n;
	logic ext_sel;

	assign {main_disk_change_n_n, main_rdata_n, main_wp_n, main_trk0_n,
		main_index_n} = main_sync;
	assign ext_disk_change_n = par_sync[`FDPM_PD_DISK_CHANGE_N];
	assign ext_sel = ext_mode & core_ext_access;

	// ------------------------------------------------------------
	// Drive status to core
	// ------------------------------------------------------------
	// Levels follow the drive as-is: active low at the pin
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			drv_disk_change_n <= 1'b1;
			drv_read_serial_n <= 1'b1;
			drv_write_protect_n <= 1'b1;
			drv_track_zero_n <= 1'b1;
			drv_index_n <= 1'b1;
		end else if (ext_sel) begin
			drv_disk_change_n <= ext_disk_change_n;
			drv_read_serial_n <= par_sync[`FDPM_PD_RDATA];
			drv_write_protect_n <= par_sync[`FDPM_PD_WPROT];
			drv_track_zero_n <= par_sync[`FDPM_PD_TRACK0];
			drv_index_n <= par_sync[`FDPM_PD_INDEX];
		end else begin
			drv_disk_change_n <= main_disk_change_n_n;
			drv_read_serial_n <= main_rdata_n;
			drv_write_protect_n <= main_wp_n;
			drv_track_zero_n <= main_trk0_n;
			drv_index_n <= main_index_n;
		end
	end

	assign prn_data_in = par_sync;

	// ------------------------------------------------------------
	// Pull-up control
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			drive_pullup_en <= 1'b1;
			par_pullup_en <= 8'hFF;
		end else begin
			drive_pullup_en <= ~drive_input_pullup_disable;
			// Extension inputs always pulled high; printer keeps them too
			par_pullup_en <= 8'hFF;
		end
	end

	// ------------------------------------------------------------
	// Step pulse stretcher
	// ------------------------------------------------------------
	// Strobes during a pulse are dropped: the head moves one track each
	fdpm_step_state_t step_state_r;
	logic [15:0] step_cnt_r;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			step_state_r <= FDPM_STEP_IDLE;
			step_cnt_r <= 16'h0000;
		end else begin
			case (step_state_r)
				FDPM_STEP_IDLE: begin
					if (core_step_strobe) begin
						step_state_r <= FDPM_STEP_PULSE;
						step_cnt_r <= 16'(STEP_PULSE_CYC - 1);
					end
				end
				FDPM_STEP_PULSE: begin
					if (step_cnt_r == 16'h0000) begin
						step_state_r <= FDPM_STEP_IDLE;
					end else begin
						step_cnt_r <= step_cnt_r - 16'h0001;
					end
				end
				default: begin
					step_state_r <= FDPM_STEP_IDLE;
					step_cnt_r <= 16'h0000;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Main drive open-drain outputs
	// ------------------------------------------------------------
	// Open-drain levels are always low; the enable alone carries state
	assign head_sel_n_o = 1'b0;
	assign write_gate_n_o = 1'b0;
	assign write_serial_n_o = 1'b0;
	assign step_n_o = 1'b0;
	assign dir_n_o = 1'b0;
	assign motor_a_on_n_o = 1'b0;
	assign motor_b_on_n_o = 1'b0;
	assign drive_sel_a_n_o = 1'b0;
	assign drive_sel_b_n_o = 1'b0;
	assign density_sel_bit0_o = 1'b0;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			head_sel_n_oe <= 1'b0;
			write_gate_n_oe <= 1'b0;
			write_serial_n_oe <= 1'b0;
			step_n_oe <= 1'b0;
			dir_n_oe <= 1'b0;
			motor_a_on_n_oe <= 1'b0;
			motor_b_on_n_oe <= 1'b0;
			drive_sel_a_n_oe <= 1'b0;
			drive_sel_b_n_oe <= 1'b0;
			density_sel_bit0_oe <= 1'b0;
		end else begin
			head_sel_n_oe <= core_head_side1;
			write_gate_n_oe <= core_write_gate;
			// Data only reaches the cable while writing is enabled
			write_serial_n_oe <= core_write_gate & core_write_pulse;
			step_n_oe <= (step_state_r == FDPM_STEP_PULSE);
			dir_n_oe <= core_dir_inward;
			motor_a_on_n_oe <= core_motor_a_on;
			motor_b_on_n_oe <= core_motor_b_on;
			drive_sel_a_n_oe <= core_drive_sel_a;
			drive_sel_b_n_oe <= core_drive_sel_b;
			density_sel_bit0_oe <= ~core_density0;
		end
	end

	// ------------------------------------------------------------
	// Shared density pin
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			density_sel_bit1_o <= 1'b0;
			density_sel_bit1_oe <= 1'b0;
		end else begin
			case (den_pin_func)
				`FDPM_DEN_FUNC_DENSITY: begin
					density_sel_bit1_o <= 1'b0;
					density_sel_bit1_oe <= ~core_density1;
				end
				`FDPM_DEN_FUNC_GPIO: begin
					density_sel_bit1_o <= gpio_port1_bit0_o;
					density_sel_bit1_oe <= gpio_port1_bit0_oe;
				end
				`FDPM_DEN_FUNC_KBC: begin
					density_sel_bit1_o <= kbc_port_o;
					density_sel_bit1_oe <= kbc_port_oe;
				end
				default: begin
					// Driven at all times here, unlike the other functions
					density_sel_bit1_o <= system_control_irq_n;
					density_sel_bit1_oe <= 1'b1;
				end
			endcase
		end
	end

	// Unselected users see an idle high input
	assign gpio_port1_bit0 =
		(den_pin_func == `FDPM_DEN_FUNC_GPIO) ? den1_sync : 1'b1;
	assign irq_channel_in1 = gpio_port1_bit0;
	assign kbc_port_pin =
		(den_pin_func == `FDPM_DEN_FUNC_KBC) ? den1_sync : 1'b1;

	// ------------------------------------------------------------
	// Parallel data pins
	// ------------------------------------------------------------
	logic [7:0] par_o_nxt;
	logic [7:0] par_oe_nxt;

	always_comb begin
		par_o_nxt = prn_data_o;
		par_oe_nxt = {8{prn_data_oe}};
		if (ext_mode) begin
			// Bits 0 to 4 are inputs, bit 5 floats
			par_o_nxt = 8'h00;
			par_oe_nxt = 8'h00;
			if (mode == FDPM_EXT_DUAL) begin
				par_oe_nxt[`FDPM_PD_MOTOR_A] = core_ext_motor_a_on;
				par_oe_nxt[`FDPM_PD_SEL_A] = core_ext_drive_sel_a;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			par_data_pin_o <= 8'h00;
			par_data_pin_oe <= 8'h00;
		end else begin
			par_data_pin_o <= par_o_nxt;
			par_data_pin_oe <= par_oe_nxt;
		end
	end

endmodule : fdpm_top

// >>> src/fdpm_params.svh
// Constants for the floppy drive pin interface and pin sharing
`ifndef FDPM_PARAMS_SVH
`define FDPM_PARAMS_SVH

// Clock
`define FDPM_CLK_PERIOD_NS 5

// Extension mode select field codes
`define FDPM_MODE_PRINTER 2'h0
`define FDPM_MODE_EXT_SINGLE 2'h1
`define FDPM_MODE_EXT_DUAL 2'h2

// Second density pin function field codes (reset value is density)
`define FDPM_DEN_FUNC_DENSITY 2'h0
`define FDPM_DEN_FUNC_GPIO 2'h1
`define FDPM_DEN_FUNC_KBC 2'h2
`define FDPM_DEN_FUNC_SCI 2'h3

// Parallel data pin positions used in extension modes
`define FDPM_PD_INDEX 0
`define FDPM_PD_TRACK0 1
`define FDPM_PD_WPROT 2
`define FDPM_PD_RDATA 3
`define FDPM_PD_DISK_CHANGE_N 4
`define FDPM_PD_SPARE 5
`define FDPM_PD_MOTOR_A 6
`define FDPM_PD_SEL_A 7

// Step pulse width
`define FDPM_STEP_PULSE_NS 3000
`define FDPM_STEP_PULSE_CYC \
	((`FDPM_STEP_PULSE_NS + `FDPM_CLK_PERIOD_NS - 1) / `FDPM_CLK_PERIOD_NS)

`endif

// >>> src/fdpm_pkg.sv
// Types for the floppy drive pin interface and pin sharing
package fdpm_pkg;

	typedef enum logic [1:0] {
		FDPM_PRINTER,
		FDPM_EXT_SINGLE,
		FDPM_EXT_DUAL
	} fdpm_mode_t;

	typedef enum logic {
		FDPM_STEP_IDLE,
		FDPM_STEP_PULSE
	} fdpm_step_state_t;

endpackage : fdpm_pkg

// >>> src/fdpm_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module fdpm_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input wire logic mclk, // System clock
	input wire logic sys_rst, // Async reset, active high
	input wire logic [WIDTH-1:0] async_in, // Raw pin levels
	output logic [WIDTH-1:0] sync_out // Synchronised levels
);

	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : fdpm_sync

// >>> dv/fdpm_monitor.sv
// Checker of the drive-side pin behaviour of the floppy pin mux
`timescale 1ns/100ps
module fdpm_monitor #(
	parameter int STEP_PULSE_CYC = 4
) (
	input wire logic mclk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic [1:0] ext_mode_sel, // Mode
	input wire logic [1:0] den_pin_func, // Density pin use
	input wire logic drive_input_pullup_disable, // Pull-up kill
	input wire logic core_head_side1, // Side
	input wire logic core_write_gate, // Gate
	input wire logic core_write_pulse, // Data
	input wire logic core_step_strobe, // Step
	input wire logic core_dir_inward, // Direction
	input wire logic core_motor_a_on, // Motor A
	input wire logic core_motor_b_on, // Motor B
	input wire logic core_drive_sel_a, // Select A
	input wire logic core_drive_sel_b, // Select B
	input wire logic core_density1, // Density 1
	input wire logic core_ext_motor_a_on, // Ext motor
	input wire logic core_ext_drive_sel_a, // Ext select
	input wire logic system_control_irq_n, // SCI level
	input wire logic head_sel_n_oe, // Head drive
	input wire logic write_gate_n_oe, // Gate drive
	input wire logic write_serial_n_oe, // Data drive
	input wire logic step_n_oe, // Step drive
	input wire logic dir_n_oe, // Direction drive
	input wire logic motor_a_on_n_oe, // Motor A drive
	input wire logic motor_b_on_n_oe, // Motor B drive
	input wire logic drive_sel_a_n_oe, // Select A drive
	input wire logic drive_sel_b_n_oe, // Select B drive
	input wire logic density_sel_bit1_o, // Density 1 level
	input wire logic density_sel_bit1_oe, // Density 1 drive
	input wire logic drive_pullup_en, // Pull-ups on
	input wire logic [7:0] par_data_pin_oe, // Parallel drive
	input wire logic [7:0] par_pullup_en // Parallel pull-ups
);
	int hi_r;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Counts how long the step line has been pulled
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			hi_r <= 0;
		end else begin
			hi_r <= step_n_oe ? hi_r + 1 : 0;
		end
	end
	AST_HEAD_SIDE: assert property (head_sel_n_oe == $past(core_head_side1))
		else $error("head select drive wrong");
	AST_WRITE_DATA: assert property (write_serial_n_oe ==
		$past(core_write_gate && core_write_pulse) &&
		write_gate_n_oe == $past(core_write_gate))
		else $error("write drive wrong");
	// Strobe edge sets the state, the next edge sets the pin drive
	AST_STEP_START: assert property ($rose(step_n_oe) |->
		$past(core_step_strobe, 2)) else $error("step without strobe");
	AST_STEP_WIDTH: assert property ($fell(step_n_oe) |->
		hi_r == STEP_PULSE_CYC) else $error("step width wrong");
	AST_DIRECTION: assert property (dir_n_oe == $past(core_dir_inward))
		else $error("direction drive wrong");
	AST_MOTORS: assert property (motor_a_on_n_oe == $past(core_motor_a_on) &&
		motor_b_on_n_oe == $past(core_motor_b_on)) else $error("motor wrong");
	AST_SELECTS: assert property (drive_sel_a_n_oe == $past(core_drive_sel_a) &&
		drive_sel_b_n_oe == $past(core_drive_sel_b)) else $error("select wrong");
	AST_EXT_FLOAT: assert property ($past(ext_mode_sel) inside {1, 2} |->
		par_data_pin_oe[5:0] == 6'h00 &&
		($past(ext_mode_sel) == 2 || par_data_pin_oe[7:6] == 2'h0))
		else $error("ext pins not floated");
	AST_EXT_DUAL: assert property ($past(ext_mode_sel) == 2 |->
		par_data_pin_oe[7:6] ==
		{$past(core_ext_drive_sel_a), $past(core_ext_motor_a_on)})
		else $error("ext drive A pins wrong");
	// Reset holds the pin released, so skip the edge that leaves reset
	AST_DEN_BIT1: assert property (!$past(sys_rst) && $past(den_pin_func) == 0 |->
		density_sel_bit1_oe == !$past(core_density1))
		else $error("density bit 1 wrong");
	AST_DEN_SCI: assert property ($past(den_pin_func) == 3 |->
		density_sel_bit1_oe && density_sel_bit1_o == $past(system_control_irq_n))
		else $error("SCI pin wrong");
	AST_PULLUPS: assert property (par_pullup_en == 8'hFF &&
		drive_pullup_en == !$past(drive_input_pullup_disable))
		else $error("pull-up enable wrong");
endmodule : fdpm_monitor

bind fdpm_top fdpm_monitor #(.STEP_PULSE_CYC(STEP_PULSE_CYC)) mon (.*);

// >>> dv/fdpm_drive_model.sv
// Behavioural floppy drives on the cable, main and extension
`timescale 1ns/100ps
module fdpm_drive_model (
	input wire logic mclk, // Clock
	input wire logic sel, // Main drive selected
	input wire logic step, // Step line pulled
	input wire logic [4:0] st, // Main status, high = active
	input wire logic [4:0] ext_st, // Extension status
	output logic disk_change_n, // Disk change line
	output logic read_serial_n, // Read data line
	output logic write_protect_n, // Write protect line
	output logic track_zero_n, // Track zero line
	output logic index_n, // Index line
	output logic [4:0] ext_n // Extension lines, bit 0 index
);
	logic fresh_r = 1'b1;
	// Power-up change flag clears on a step, as real drives do
	always @(posedge mclk) begin
		if (step) begin
			fresh_r <= 1'b0;
		end
	end
	// Unselected drive releases its lines to the pull-ups
	assign disk_change_n = !(sel && (st[4] || fresh_r));
	assign read_serial_n = !(sel && st[3]);
	assign write_protect_n = !(sel && st[2]);
	assign track_zero_n = !(sel && st[1]);
	assign index_n = !(sel && st[0]);
	assign ext_n = ~ext_st;
endmodule : fdpm_drive_model

// >>> dv/testbench.sv
// Self-checking bench of the floppy drive pin mux
`timescale 1ns/100ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin \
	num_errors++; $display("Error %s exp %0h got %0h", nm, e, a); end end
module testbench;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] ext_mode_sel, den_pin_func;
	logic drive_input_pullup_disable, core_head_side1, core_write_gate;
	logic core_write_pulse, core_step_strobe, core_dir_inward;
	logic core_motor_a_on, core_motor_b_on, core_drive_sel_a;
	logic core_drive_sel_b, core_density0, core_density1;
	logic core_ext_motor_a_on, core_ext_drive_sel_a, core_ext_access;
	logic drv_disk_change_n, drv_read_serial_n, drv_write_protect_n;
	logic drv_track_zero_n, drv_index_n, prn_data_oe;
	logic [7:0] prn_data_o, prn_data_in, par_data_pin_i, par_data_pin_o;
	logic [7:0] par_data_pin_oe, par_pullup_en;
	logic gpio_port1_bit0_o, gpio_port1_bit0_oe, gpio_port1_bit0;
	logic irq_channel_in1, kbc_port_o, kbc_port_oe, kbc_port_pin;
	logic system_control_irq_n, head_sel_n_o, head_sel_n_oe;
	logic write_gate_n_o, write_gate_n_oe, write_serial_n_o;
	logic write_serial_n_oe, step_n_o, step_n_oe, dir_n_o, dir_n_oe;
	logic motor_a_on_n_o, motor_a_on_n_oe, motor_b_on_n_o;
	logic motor_b_on_n_oe, drive_sel_a_n_o, drive_sel_a_n_oe;
	logic drive_sel_b_n_o, drive_sel_b_n_oe, density_sel_bit0_o;
	logic density_sel_bit0_oe, density_sel_bit1_i, density_sel_bit1_o;
	logic density_sel_bit1_oe, disk_change_n, read_serial_n;
	logic write_protect_n, track_zero_n, index_n, drive_pullup_en;
	logic den_ext;
	logic [4:0] st, ext_st, ext_n;
	int num_errors = 0;
	int total_checks = 0;
	fdpm_top #(.STEP_PULSE_CYC(4)) uut (.*);
	fdpm_drive_model drv (.mclk, .sel(drive_sel_a_n_oe | drive_sel_b_n_oe),
		.step(step_n_oe), .st, .ext_st, .disk_change_n, .read_serial_n,
		.write_protect_n, .track_zero_n, .index_n, .ext_n);
	// Pins: parallel lines resolve as wired-AND; a driven density pin overrides den_ext
	assign par_data_pin_i = (par_data_pin_oe & par_data_pin_o |
		~par_data_pin_oe) & {3'h7, ext_n};
	assign density_sel_bit1_i = density_sel_bit1_oe ? density_sel_bit1_o : den_ext;
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_levels;
		logic [8:0] tbl [4] = '{9'h000, 9'h1FF, 9'h0AA, 9'h155};
		logic [8:0] v;
		foreach (tbl[k]) begin
			v = tbl[k];
			@(posedge mclk);
			{core_head_side1, core_write_gate, core_write_pulse, core_dir_inward,
				core_motor_a_on, core_motor_b_on, core_drive_sel_a,
				core_drive_sel_b, core_density0} <= v;
			tick(2);
			`CHK("oe", {v[8], v[7], v[7] & v[6], v[5:1], ~v[0]}, {head_sel_n_oe, write_gate_n_oe, write_serial_n_oe, dir_n_oe, motor_a_on_n_oe, motor_b_on_n_oe, drive_sel_a_n_oe, drive_sel_b_n_oe, density_sel_bit0_oe})
			`CHK("od", 10'h000, {head_sel_n_o, write_gate_n_o, write_serial_n_o, step_n_o, dir_n_o, motor_a_on_n_o, motor_b_on_n_o, drive_sel_a_n_o, drive_sel_b_n_o, density_sel_bit0_o})
		end
		$display("levels done");
	endtask : t_levels
	task t_step;
		@(posedge mclk);
		core_step_strobe <= 1'b1;
		@(posedge mclk);
		core_step_strobe <= 1'b0;
		tick(1);
		`CHK("step on", 1'b1, step_n_oe)
		// Second strobe lands inside the pulse and must be dropped
		@(posedge mclk);
		core_step_strobe <= 1'b1;
		@(posedge mclk);
		core_step_strobe <= 1'b0;
		tick(1);
		`CHK("step held", 1'b1, step_n_oe)
		tick(1);
		`CHK("step end", 1'b0, step_n_oe)
		tick(3);
		`CHK("step ignored", 1'b0, step_n_oe)
		$display("step done");
	endtask : t_step
	task t_pins;
		@(posedge mclk);
		core_drive_sel_a <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			st <= 5'h01 << i;
			tick(4);
			`CHK("drv", ~(5'h01 << i), {drv_disk_change_n, drv_read_serial_n, drv_write_protect_n, drv_track_zero_n, drv_index_n})
			@(posedge mclk);
		end
		st <= 5'h1F;
		ext_mode_sel <= 2'h1;
		core_ext_access <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			ext_st <= 5'h01 << i;
			tick(5);
			`CHK("ext", ~(5'h01 << i), {drv_disk_change_n, drv_read_serial_n, drv_write_protect_n, drv_track_zero_n, drv_index_n})
			@(posedge mclk);
		end
		{ext_mode_sel, core_ext_access, st, ext_st} <= '0;
		$display("pins done");
	endtask : t_pins
	task t_modes;
		logic [7:0] exp [4] = '{8'hFF, 8'h00, 8'hC0, 8'hFF};
		logic [7:0] exp_o [4] = '{8'hC3, 8'h00, 8'h00, 8'hC3};
		foreach (exp[m]) begin
			@(posedge mclk);
			ext_mode_sel <= 2'(m);
			{prn_data_o, prn_data_oe, core_ext_motor_a_on,
				core_ext_drive_sel_a} <= {8'hC3, 3'h7};
			tick(2);
			`CHK("par oe", exp[m], par_data_pin_oe)
			`CHK("par o", exp_o[m], par_data_pin_o & par_data_pin_oe)
		end
		@(posedge mclk);
		{ext_mode_sel, prn_data_oe, core_ext_motor_a_on,
			core_ext_drive_sel_a} <= '0;
		$display("modes done");
	endtask : t_modes
	task t_density;
		logic [3:0] exp [4] = '{4'hF, 4'h9, 4'h6, 4'hF};
		@(posedge mclk);
		{gpio_port1_bit0_oe, core_density1, den_ext} <= 3'h4;
		for (int f = 0; f < 4; f++) begin
			den_pin_func <= 2'(f);
			tick(4);
			`CHK("den", exp[f], {density_sel_bit1_oe, gpio_port1_bit0, irq_channel_in1, kbc_port_pin})
			@(posedge mclk);
		end
		{den_pin_func, gpio_port1_bit0_oe, den_ext} <= 4'h1;
		$display("density done");
	endtask : t_density
	task t_pullup;
		for (int d = 0; d < 2; d++) begin
			@(posedge mclk);
			drive_input_pullup_disable <= 1'(d);
			tick(2);
			`CHK("pullup", {1'(~d), 8'hFF}, {drive_pullup_en, par_pullup_en})
		end
		$display("pullup done");
	endtask : t_pullup
	task print_verdict;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		{ext_mode_sel, den_pin_func, drive_input_pullup_disable} = '0;
		{core_head_side1, core_write_gate, core_write_pulse} = '0;
		{core_step_strobe, core_dir_inward, core_motor_a_on} = '0;
		{core_motor_b_on, core_drive_sel_a, core_drive_sel_b} = '0;
		{core_density0, core_density1, core_ext_motor_a_on} = '0;
		{core_ext_drive_sel_a, core_ext_access, prn_data_o, prn_data_oe} = '0;
		{gpio_port1_bit0_o, gpio_port1_bit0_oe, kbc_port_o, kbc_port_oe} = '0;
		{system_control_irq_n, den_ext, st, ext_st} = '0;
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		t_levels();
		t_step();
		t_pins();
		t_modes();
		t_density();
		t_pullup();
		print_verdict();
	end
	// Whole run is about 135 cycles
	initial begin
		#20us;
		num_errors++;
		print_verdict();
	end
endmodule : testbench
